// ### shared/fifo_read_regs.vh
// Notes on behaviour
// R1 - Pointer clear zeroes both pointers and output
// R2 - Pointer clear keeps modes and offsets
// R3 - Output bus is 36, 18 or 9 wide
// R4 - Synchronous read on gated read clock edge
// R5 - Offset access low outputs offset registers
// R6 - Asynchronous mode reads on every strobe edge; the code only reads when read select was low at that edge
// R7 - Reader holds read gate low when asynchronous
// R8 - Read select sampled on read clock, gates outputs
// R9 - Resets ignore select; enable alone drives outputs
// R10 - Rewind resets read pointer, forces empty
// R11 - Rewind goes to mark when mark set
// R12 - Mark captures current read pointer
// R13 - Shift clock edge shifts serial bit in
// R14 - Fall-through strap pin later is serial input
// R15 - Reader keeps offset access high for memory
`ifndef FIFO_READ_REGS_VH
`define FIFO_READ_REGS_VH

// Register byte offsets
`define OFS_CTRL       5'h00
`define OFS_STATUS     5'h04
`define OFS_IRQ_STAT   5'h08
`define OFS_IRQ_MASK   5'h0c
`define OFS_PUSH_LO    5'h10
`define OFS_PUSH_HI    5'h14
`define OFS_EMPTY_OFS  5'h18
`define OFS_FULL_OFS   5'h1c

// Control fields
`define CTRL_ASYNC     0
`define CTRL_SIZE_LO   1
`define CTRL_SIZE_HI   2
`define CTRL_RST       3'h0

// Bus size codes
`define SIZE_36        2'h0
`define SIZE_18        2'h1
`define SIZE_9         2'h2

// Status fields
`define STAT_EMPTY     0
`define STAT_VALID     1
`define STAT_FALL_THROUGH_MODE      2
`define STAT_MARK      3
`define STAT_CNT_LO    16

// Interrupt bits
`define IRQ_REWIND     0
`define IRQ_DRAINED    1
`define IRQ_PCLR       2
`define IRQ_OVERFLOW   3
`define IRQ_RST        4'h0

// Offset register defaults
`define OFS_W_DEF      10
`define OFS_EMPTY_DEF  10'h07f
`define OFS_FULL_DEF   10'h07f

// Pin synchroniser layout and idle levels
`define PIN_N          12
`define PIN_RCLK       0
`define PIN_GATE_N     1
`define PIN_SEL_N      2
`define PIN_LD_N       3
`define PIN_RT_N       4
`define PIN_MARK       5
`define PIN_SCLK       6
`define PIN_SEN_N      7
`define PIN_SI         8
`define PIN_PCLR_N     9
`define PIN_INIT_N     10
`define PIN_OE_N       11
`define SYNC_INIT      12'he9e

`endif

// ### rtl/pin_sync3.v
`timescale 1ns/100ps
module pin_sync3 #(
  parameter            W    = 12,
  parameter [W-1:0]    INIT = {W{1'b0}}
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // Raw pins and filtered levels
  input  wire [W-1:0]  pin,
  output reg  [W-1:0]  level_r
);

  reg  [W-1:0]         s1_r;
  reg  [W-1:0]         s2_r;
  reg  [W-1:0]         s3_r;
  wire [W-1:0]         agree = ~(s2_r ^ s3_r);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r    <= INIT;
      s2_r    <= INIT;
      s3_r    <= INIT;
      level_r <= INIT;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      // A change counts once stages two and three agree
      level_r <= (s3_r & agree) | (level_r & ~agree);
    end
  end

endmodule // pin_sync3

// ### rtl/offset_shift.v
`timescale 1ns/100ps
`include "fifo_read_regs.vh"
module offset_shift #(
  parameter            W = `OFS_W_DEF
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // Control
  input  wire          init,
  input  wire          shift_ev,
  input  wire          bit_in,
  // Offset values
  output wire [W-1:0]  empty_ofs,
  output wire [W-1:0]  full_ofs
);

  localparam [W-1:0]   DEF_E = `OFS_EMPTY_DEF;
  localparam [W-1:0]   DEF_F = `OFS_FULL_DEF;

  reg  [2*W-1:0]       chain_r;

  // Pointer clear does not reach here, so offsets survive it
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chain_r <= {DEF_E, DEF_F};
    end else if (init) begin
      chain_r <= {DEF_E, DEF_F};
    end else if (shift_ev) begin
      chain_r <= {chain_r[2*W-2:0], bit_in}; // R13
    end
  end

  assign empty_ofs = chain_r[2*W-1:W];
  assign full_ofs  = chain_r[W-1:0];

endmodule // offset_shift

// ### rtl/fifo_read_port_control.v
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "fifo_read_regs.vh"
module fifo_read_port_control #(
  parameter            AW    = 4,
  parameter            OFS_W = `OFS_W_DEF
) (
  // Clock and reset
  input  wire          clk,
  input  wire          resetn,
  // Avalon-MM slave
  input  wire [4:0]    address,
  input  wire          read,
  input  wire          write,
  input  wire [31:0]   writedata,
  output reg  [31:0]   readdata,
  output reg           waitrequest,
  output reg           irq,
  // Read port pins
  input  wire          read_clk,
  input  wire          read_gate_n,
  input  wire          read_select_n,
  input  wire          output_enable_n,
  input  wire          offset_access_n,
  input  wire          rewind_n,
  input  wire          mark,
  // Offset serial load pins
  input  wire          offset_shift_clk,
  input  wire          offset_shift_enable_n,
  input  wire          fall_through_mode,
  // Reset pins
  input  wire          pointer_clear_keep_config_n,
  input  wire          full_init_n,
  // Outputs
  output reg  [35:0]   read_data_out,
  output reg           read_data_oe,
  output reg           empty_flag_n,
  output reg           output_valid
);

  localparam           DEPTH = 1 << AW;
  localparam [AW:0]    FULL_CNT = {1'b1, {AW{1'b0}}};
  localparam [AW:0]    ONE_CNT = {{AW{1'b0}}, 1'b1};

  // Synchronised pins
  wire [`PIN_N-1:0]    pin_f;
  wire [`PIN_N-1:0]    pins;

  assign pins = {output_enable_n, full_init_n, pointer_clear_keep_config_n,
                 fall_through_mode, offset_shift_enable_n, offset_shift_clk,
                 mark, rewind_n, offset_access_n, read_select_n, read_gate_n,
                 read_clk};

  pin_sync3 #(
    .W    (`PIN_N),
    .INIT (`SYNC_INIT)
  ) i_pin_sync3 (
    .clk     (clk),
    .resetn  (resetn),
    .pin     (pins),
    .level_r (pin_f)
  );

  // State
  reg  [35:0]          mem [0:DEPTH-1];
  reg  [AW:0]          wr_ptr_r;
  reg  [AW:0]          rd_ptr_r;
  reg  [AW:0]          mark_ptr_r;
  reg                  mark_valid_r;
  reg  [35:0]          word_r;
  reg                  have_r;
  reg  [1:0]           piece_r;
  reg                  ofs_sel_r;
  reg                  forced_empty_r;
  reg                  sel_q_r;
  reg                  rclk_d_r;
  reg                  sclk_d_r;
  reg                  init_d_r;
  reg                  pclr_d_r;
  reg                  fall_through_mode_r;
  reg  [2:0]           ctrl_r;
  reg  [3:0]           irq_stat_r;
  reg  [3:0]           irq_mask_r;
  reg  [3:0]           push_hi_r;
  reg  [3:0]           irq_ev;
  reg  [31:0]          rd_mux;

  wire [OFS_W-1:0]     empty_ofs;
  wire [OFS_W-1:0]     full_ofs;
  wire [1:0]           bus_size = ctrl_r[`CTRL_SIZE_HI:`CTRL_SIZE_LO];
  wire                 async_rd = ctrl_r[`CTRL_ASYNC];
  wire                 init_act = ~pin_f[`PIN_INIT_N];
  wire                 pclr_act = ~pin_f[`PIN_PCLR_N];
  wire                 in_rst   = init_act | pclr_act;
  wire                 rclk_rise = pin_f[`PIN_RCLK] & ~rclk_d_r;
  wire                 sclk_rise = pin_f[`PIN_SCLK] & ~sclk_d_r;
  wire [AW:0]          count = wr_ptr_r - rd_ptr_r;
  wire                 fifo_empty = (count == {(AW+1){1'b0}});
  wire                 fifo_full  = (count == FULL_CNT);
  wire [35:0]          head = mem[rd_ptr_r[AW-1:0]];
  wire [35:0]          ofs_word = ofs_sel_r ? {{(36-OFS_W){1'b0}}, full_ofs}
                                            : {{(36-OFS_W){1'b0}}, empty_ofs};
  wire                 access = write | read;
  wire                 bus_take = access & ~waitrequest;
  wire                 push = bus_take & write & (address == `OFS_PUSH_LO);

  // Read request: gate ignored in strobe mode, select always gates
  wire                 sel_q_nxt = rclk_rise ? pin_f[`PIN_SEL_N] : sel_q_r; // R8
  wire                 rd_ev = rclk_rise & ~sel_q_nxt &
                               (async_rd | ~pin_f[`PIN_GATE_N]); // R4 R6 R7 R8
  wire                 rewind_ev = rclk_rise & ~pin_f[`PIN_RT_N];
  wire                 ofs_rd = rd_ev & ~pin_f[`PIN_LD_N];
  wire                 can_step = have_r & (piece_r != last_piece(bus_size));
  // Forced empty only holds back fall-through; a read edge still reads
  wire                 load = ~fifo_empty &
                              ((rd_ev & ~ofs_rd & ~can_step) |
                               (fall_through_mode_r & ~have_r & ~forced_empty_r));

  // Last piece index for a bus size
  function [1:0] last_piece;
    input [1:0] size;
    begin
      case (size)
        `SIZE_18: last_piece = 2'h1;
        `SIZE_9:  last_piece = 2'h3;
        default:  last_piece = 2'h0;
      endcase
    end
  endfunction

  // Narrow pieces sit in the low bits, low part first
  function [35:0] piece_sel;
    input [35:0] w;
    input [1:0]  size;
    input [1:0]  pc;
    begin
      case (size)
        `SIZE_18: piece_sel = pc[0] ? {18'h00000, w[35:18]} : {18'h00000, w[17:0]};
        `SIZE_9: begin
          case (pc)
            2'h0:    piece_sel = {27'h0000000, w[8:0]};
            2'h1:    piece_sel = {27'h0000000, w[17:9]};
            2'h2:    piece_sel = {27'h0000000, w[26:18]};
            default: piece_sel = {27'h0000000, w[35:27]};
          endcase
        end
        default: piece_sel = w;
      endcase
    end
  endfunction // R3

  offset_shift #(
    .W (OFS_W)
  ) i_offset_shift (
    .clk       (clk),
    .resetn    (resetn),
    .init      (init_act),
    .shift_ev  (sclk_rise & ~pin_f[`PIN_SEN_N] & ~init_act), // R13
    .bit_in    (pin_f[`PIN_SI]), // R14
    .empty_ofs (empty_ofs),
    .full_ofs  (full_ofs)
  );

  // Edge trackers and strap capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rclk_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
      init_d_r <= 1'b0;
      pclr_d_r <= 1'b1;
      fall_through_mode_r   <= 1'b0;
      sel_q_r  <= 1'b1;
    end else begin
      rclk_d_r <= pin_f[`PIN_RCLK];
      sclk_d_r <= pin_f[`PIN_SCLK];
      init_d_r <= pin_f[`PIN_INIT_N];
      pclr_d_r <= pin_f[`PIN_PCLR_N];
      sel_q_r  <= sel_q_nxt;
      if (pin_f[`PIN_INIT_N] && !init_d_r) begin
        fall_through_mode_r <= pin_f[`PIN_SI]; // R14
      end
    end
  end

  // Write side fed from the register bus
  always @(posedge clk) begin
    if (push && !fifo_full && !in_rst) begin
      mem[wr_ptr_r[AW-1:0]] <= {push_hi_r, writedata};
    end
  end

  // Read side
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r       <= {(AW+1){1'b0}};
      rd_ptr_r       <= {(AW+1){1'b0}};
      mark_ptr_r     <= {(AW+1){1'b0}};
      mark_valid_r   <= 1'b0;
      word_r         <= 36'h000000000;
      have_r         <= 1'b0;
      piece_r        <= 2'h0;
      ofs_sel_r      <= 1'b0;
      forced_empty_r <= 1'b0;
      read_data_out  <= 36'h000000000;
    end else if (in_rst) begin
      wr_ptr_r       <= {(AW+1){1'b0}}; // R1
      rd_ptr_r       <= {(AW+1){1'b0}}; // R1
      mark_valid_r   <= 1'b0;
      word_r         <= 36'h000000000;
      have_r         <= 1'b0;
      piece_r        <= 2'h0;
      ofs_sel_r      <= 1'b0;
      forced_empty_r <= 1'b0;
      read_data_out  <= 36'h000000000; // R1 R2
    end else begin
      if (push && !fifo_full) begin
        wr_ptr_r <= wr_ptr_r + ONE_CNT;
      end
      if (rclk_rise && pin_f[`PIN_MARK]) begin
        mark_ptr_r   <= rd_ptr_r; // R12
        mark_valid_r <= 1'b1;
      end
      if (rewind_ev) begin
        rd_ptr_r       <= mark_valid_r ? mark_ptr_r : {(AW+1){1'b0}}; // R10 R11
        forced_empty_r <= 1'b1; // R10
        have_r         <= 1'b0; // R10
        piece_r        <= 2'h0;
      end else begin
        if (rclk_rise) begin
          forced_empty_r <= 1'b0;
        end
        if (ofs_rd) begin
          read_data_out <= ofs_word; // R5
          ofs_sel_r     <= ~ofs_sel_r;
        end else if (rd_ev && can_step) begin
          piece_r       <= piece_r + 2'h1;
          read_data_out <= piece_sel(word_r, bus_size, piece_r + 2'h1); // R3
        end else if (load) begin
          word_r        <= head; // R4 R6
          have_r        <= 1'b1;
          piece_r       <= 2'h0;
          rd_ptr_r      <= rd_ptr_r + ONE_CNT;
          read_data_out <= piece_sel(head, bus_size, 2'h0);
        end else if (rd_ev && fall_through_mode_r && have_r) begin
          have_r <= 1'b0;
        end
      end
    end
  end

  // Flags and output drive
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_data_oe <= 1'b0;
      empty_flag_n <= 1'b0;
      output_valid <= 1'b0;
    end else begin
      read_data_oe <= ~pin_f[`PIN_OE_N] & (in_rst | ~sel_q_r); // R8 R9
      empty_flag_n <= ~(fifo_empty | forced_empty_r | in_rst); // R10
      output_valid <= fall_through_mode_r & have_r & ~forced_empty_r & ~in_rst; // R10
    end
  end

  // Interrupt events
  always @* begin
    irq_ev                = 4'h0;
    irq_ev[`IRQ_REWIND]   = rewind_ev & ~in_rst;
    irq_ev[`IRQ_DRAINED]  = load & (count == ONE_CNT) & ~in_rst;
    irq_ev[`IRQ_PCLR]     = ~pin_f[`PIN_PCLR_N] & pclr_d_r;
    irq_ev[`IRQ_OVERFLOW] = push & fifo_full;
  end

  // Read mux
  always @* begin
    rd_mux = 32'h00000000;
    case (address)
      `OFS_CTRL:      rd_mux = {29'h00000000, ctrl_r};
      `OFS_STATUS: begin
        rd_mux[`STAT_EMPTY] = fifo_empty;
        rd_mux[`STAT_VALID] = have_r;
        rd_mux[`STAT_FALL_THROUGH_MODE]  = fall_through_mode_r;
        rd_mux[`STAT_MARK]  = mark_valid_r;
        rd_mux[`STAT_CNT_LO+AW:`STAT_CNT_LO] = count;
      end
      `OFS_IRQ_STAT:  rd_mux = {28'h0000000, irq_stat_r};
      `OFS_IRQ_MASK:  rd_mux = {28'h0000000, irq_mask_r};
      `OFS_PUSH_HI:   rd_mux = {28'h0000000, push_hi_r};
      `OFS_EMPTY_OFS: rd_mux = {{(32-OFS_W){1'b0}}, empty_ofs};
      `OFS_FULL_OFS:  rd_mux = {{(32-OFS_W){1'b0}}, full_ofs};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // Avalon slave, one wait cycle per access
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      ctrl_r      <= `CTRL_RST;
      irq_stat_r  <= `IRQ_RST;
      irq_mask_r  <= `IRQ_RST;
      push_hi_r   <= 4'h0;
      irq         <= 1'b0;
    end else begin
      waitrequest <= ~(access & waitrequest);
      if (access && waitrequest) begin
        readdata <= rd_mux;
      end
      if (bus_take && write && address == `OFS_CTRL) begin
        ctrl_r <= writedata[2:0]; // R2
      end
      if (bus_take && write && address == `OFS_IRQ_MASK) begin
        irq_mask_r <= writedata[3:0];
      end
      if (bus_take && write && address == `OFS_PUSH_HI) begin
        push_hi_r <= writedata[3:0];
      end
      // Set wins over a same-cycle clear
      if (bus_take && write && address == `OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~writedata[3:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule // fifo_read_port_control

// ### sim/fifo_read_port_control_sva.sv
`timescale 1ns/100ps
module fifo_read_port_control_sva (
  // Clock and bus
  input wire        clk,
  input wire        resetn,
  input wire        read,
  input wire        write,
  input wire        waitrequest,
  // Read port
  input wire        read_clk,
  input wire        read_select_n,
  input wire        output_enable_n,
  input wire        pointer_clear_keep_config_n,
  input wire        full_init_n,
  input wire [35:0] read_data_out,
  input wire        read_data_oe,
  input wire        empty_flag_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire pclr = !pointer_clear_keep_config_n;
  wire run  = pointer_clear_keep_config_n && full_init_n;
  chk_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no bus answer");
  chk_clr_data: assert property (pclr [*8] |-> read_data_out == 36'h0)
    else $error("output not cleared");
  chk_clr_empty: assert property (pclr [*8] |-> !empty_flag_n)
    else $error("empty not shown");
  chk_reset_drive: assert property ((pclr && !output_enable_n) [*8] |-> read_data_oe)
    else $error("no drive in reset");
  chk_oe_off: assert property (output_enable_n [*8] |-> !read_data_oe)
    else $error("drive while disabled");
  chk_desel_hold: assert property ((read_select_n && run) [*8] |-> $stable(read_data_out))
    else $error("read while deselected");
  chk_idle_hold: assert property ((!read_clk && run) [*8] |-> $stable(read_data_out))
    else $error("read without edge");
endmodule // fifo_read_port_control_sva

// ### sim/fifo_consumer_model.sv
`timescale 1ns/100ps
module fifo_consumer_model (
  // Clock
  input  wire clk,
  // Read port pins
  output reg  read_clk,
  output reg  read_gate_n,
  output reg  read_select_n,
  output reg  output_enable_n,
  output reg  offset_access_n,
  output reg  rewind_n,
  output reg  mark,
  // Serial load pins
  output reg  offset_shift_clk,
  output reg  offset_shift_enable_n,
  output reg  fall_through_mode
);
  initial begin
    read_clk              = 1'b0;
    read_gate_n           = 1'b0;
    read_select_n         = 1'b1;
    output_enable_n       = 1'b1;
    offset_access_n       = 1'b1;
    rewind_n              = 1'b1;
    mark                  = 1'b0;
    offset_shift_clk      = 1'b0;
    offset_shift_enable_n = 1'b1;
    fall_through_mode     = 1'b0;
  end
  // Controls set up well ahead, since every pin is filtered
  task automatic rd_edge(input bit rw, input bit mk, input bit sel);
    output_enable_n <= 1'b0;
    rewind_n        <= !rw;
    mark            <= mk;
    read_select_n   <= !sel;
    repeat (5) @(posedge clk);
    read_clk <= 1'b1;
    repeat (4) @(posedge clk);
    read_clk      <= 1'b0;
    rewind_n      <= 1'b1;
    mark          <= 1'b0;
    read_select_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Offset access switched only between reads
  task automatic ofs_mode(input bit on);
    offset_access_n <= !on;
    repeat (6) @(posedge clk);
  endtask
  // Empty offset first, most significant bit first
  task automatic shift_in(input logic [19:0] v);
    offset_shift_enable_n <= 1'b0;
    for (int i = 19; i >= 0; i--) begin
      fall_through_mode <= v[i];
      repeat (4) @(posedge clk);
      offset_shift_clk <= 1'b1;
      repeat (4) @(posedge clk);
      offset_shift_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    offset_shift_enable_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // fifo_consumer_model

// ### sim/tb_fifo_read_port_control.sv
`timescale 1ns/100ps
`include "fifo_read_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_fifo_read_port_control;
  logic        clk, resetn, read, write, pclr_n, init_n;
  logic [4:0]  address;
  logic [31:0] writedata, q, readdata;
  logic        waitrequest, irq, oe, ef_n, ov;
  logic [35:0] dout;
  wire         read_clk, read_gate_n, read_select_n, output_enable_n, offset_access_n;
  wire         rewind_n, mark, offset_shift_clk, offset_shift_enable_n, fall_through_mode;
  int          errors = 0;
  int          num_checks = 0;
  localparam logic [35:0] WA = 36'h9_8765_4321;
  localparam logic [35:0] WB = 36'h1_2345_6789;

  fifo_read_port_control #(.AW(4), .OFS_W(10)) i_fifo_read_port_control (
    .clk, .resetn, .address, .read, .write, .writedata, .readdata, .waitrequest, .irq,
    .read_clk, .read_gate_n, .read_select_n, .output_enable_n, .offset_access_n,
    .rewind_n, .mark, .offset_shift_clk, .offset_shift_enable_n, .fall_through_mode,
    .pointer_clear_keep_config_n(pclr_n), .full_init_n(init_n), .read_data_out(dout),
    .read_data_oe(oe), .empty_flag_n(ef_n), .output_valid(ov));

  fifo_consumer_model i_fifo_consumer_model (
    .clk, .read_clk, .read_gate_n, .read_select_n, .output_enable_n, .offset_access_n,
    .rewind_n, .mark, .offset_shift_clk, .offset_shift_enable_n, .fall_through_mode);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    read      <= !w;
    write     <= w;
    address   <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      `CHK("timeout", 1'b0, 1'b1)
      finish_test();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic push(input logic [35:0] v);
    bus(1'b1, `OFS_PUSH_HI, {28'h0, v[35:32]});
    bus(1'b1, `OFS_PUSH_LO, v[31:0]);
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, q)
  endtask

  task automatic rd(input bit rw, input bit mk, input bit sel);
    i_fifo_consumer_model.rd_edge(rw, mk, sel);
  endtask

  // Pointer clear so that no held word carries into the next scenario
  task automatic clr_ptrs;
    pclr_n <= 1'b0;
    repeat (10) @(posedge clk);
    pclr_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_offsets;
    rd_reg(`OFS_EMPTY_OFS, {22'h0, `OFS_EMPTY_DEF}, "empty_ofs");
    i_fifo_consumer_model.shift_in({10'h155, 10'h0aa});
    rd_reg(`OFS_EMPTY_OFS, 32'h155, "empty_ofs");
    rd_reg(`OFS_FULL_OFS, 32'h0aa, "full_ofs");
    i_fifo_consumer_model.ofs_mode(1'b1);
    rd(1'b0, 1'b0, 1'b1);
    `CHK("ofs empty out", 36'h155, dout)
    rd(1'b0, 1'b0, 1'b1);
    `CHK("ofs full out", 36'h0aa, dout)
    i_fifo_consumer_model.ofs_mode(1'b0);
  endtask

  task automatic t_read;
    bus(1'b1, `OFS_CTRL, 32'h0);
    push(WA);
    push(WB);
    rd(1'b0, 1'b0, 1'b0);
    `CHK("desel", 36'h0aa, dout)
    `CHK("desel drive", 1'b0, oe)
    rd(1'b0, 1'b0, 1'b1);
    `CHK("word a", WA, dout)
    rd(1'b0, 1'b1, 1'b0);
    rd(1'b0, 1'b0, 1'b1);
    `CHK("word b", WB, dout)
    rd(1'b1, 1'b0, 1'b0);
    `CHK("empty", 1'b0, ef_n)
    `CHK("irq masked", 1'b0, irq)
    `CHK("no valid", 1'b0, ov)
    rd_reg(`OFS_STATUS, 32'h00010008, "status at mark");
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, `OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq clr", 1'b0, irq)
    rd(1'b0, 1'b0, 1'b1);
    `CHK("from mark", WB, dout)
    rd_reg(`OFS_STATUS, 32'h0000000b, "status drained");
  endtask

  // Narrow widths hand out the word lowest piece first
  task automatic t_width(input logic [1:0] sz, input int w);
    bus(1'b1, `OFS_CTRL, {29'h0, sz, 1'b0});
    clr_ptrs();
    push(WA);
    for (int i = 0; i < 36 / w; i++) begin
      rd(1'b0, 1'b0, 1'b1);
      `CHK("piece", (WA >> (w * i)) & ((36'h1 << w) - 36'h1), dout)
    end
  endtask

  task automatic t_async;
    bus(1'b1, `OFS_CTRL, 32'h1);
    clr_ptrs();
    push(WB);
    rd(1'b0, 1'b0, 1'b1);
    `CHK("strobe", WB, dout)
  endtask

  task automatic t_pclr;
    push(WA);
    pclr_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("clr out", 36'h0, dout)
    `CHK("clr empty", 1'b0, ef_n)
    `CHK("clr drive", 1'b1, oe)
    pclr_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(`OFS_EMPTY_OFS, 32'h155, "kept ofs");
    rd_reg(`OFS_CTRL, 32'h1, "kept ctrl");
    rd(1'b0, 1'b0, 1'b1);
    `CHK("cleared", 36'h0, dout)
  endtask

  initial begin
    resetn    = 1'b0;
    init_n    = 1'b0;
    pclr_n    = 1'b1;
    read      = 1'b0;
    write     = 1'b0;
    address   = 5'h00;
    writedata = 32'h0;
    repeat (6) @(posedge clk);
    `CHK("wait idle", 1'b1, waitrequest)
    `CHK("out reset", 36'h0, dout)
    resetn <= 1'b1;
    init_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_offsets();
    t_read();
    t_width(`SIZE_18, 18);
    t_width(`SIZE_9, 9);
    t_async();
    t_pclr();
    finish_test();
  end
endmodule // tb_fifo_read_port_control

bind fifo_read_port_control fifo_read_port_control_sva i_fifo_read_port_control_sva (
  .clk, .resetn, .read, .write, .waitrequest, .read_clk, .read_select_n,
  .output_enable_n, .pointer_clear_keep_config_n, .full_init_n, .read_data_out,
  .read_data_oe, .empty_flag_n);
